// ==== rtl/ctac_ctrl.sv ====
/*
 Radio controller slice: channel assessment, signal quality capture,
 transmit-to-receive turnaround, frame filter and auto-acknowledge gating.
 Assumes a host on the plain register port, and RSSI, SQI and frame
 parser results arriving from logic on the same 250 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ctac_defs.svh"
// Notes on behaviour
// - Energy threshold assessment works in both 802.15.4 and GFSK/FSK modes.
// - Assessment starts on the assess command, or on entering receive with the auto-assess bit set.
// - Averaging begins after receive delay plus extended delay has elapsed.
// - Average below threshold sets channel clear, else clears; then done pulse.
// - Single assessment: go to idle after one window, done pulse one cycle later.
// - Repeat assessment: restart window at each done until go-idle command.
// - First repeated done follows first window after the delay.
// - RSSI readback holds old value, refreshed one cycle before done pulse.
// - Averaging field selects 16, 32, 64 or 128 microseconds.
// - Eight-bit signal quality readback, rising with quality, unscaled.
// - Packet mode with checksum check on stores frame SQI as second FCS byte.
// - Turnaround enabled in 802.15.4 packet mode: after a transmit other than an acknowledge, enter receive after the delay.
// - In turnaround, a valid received frame sends the radio to idle, or to transmit when it is to be acknowledged.
// - Filter enabled in packet mode rejects frames not addressed here.
// - Auto-acknowledge only acts while frame filtering is active.
// - Acknowledge only filtered, non-beacon, non-ack frames requesting one.
// - Receive delay counts 1 us steps, extended delay 4 us steps, summed.
// - Auto-assess bit set makes receive entry start an assessment.
module ctac_ctrl
   import ctac_pkg::*;
#(
   parameter int unsigned ADDR_W = 10
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] rssi_in,
   input wire logic sqi_valid_in,
   input wire logic [7:0] sqi_in,
   input wire logic addon_loaded_in,
   input wire logic frame_start_in,
   input wire logic frame_end_in,
   input wire logic fcs_ok_in,
   input wire logic dest_match_in,
   input wire logic [2:0] frame_type_in,
   input wire logic ack_request_in,
   input wire logic tx_done_in,
   output logic [7:0] reg_rdata_out,
   output logic [5:0] radio_state_out,
   output logic channel_clear_out,
   output logic cca_complete_out,
   output logic tx_start_out,
   output logic ack_tx_start_out,
   output logic frame_reject_out,
   output logic sqi_store_we_out,
   output logic [7:0] sqi_store_data_out
);
   logic [7:0] thr_q, assess_cfg_q, rxbuf_cfg_q, pkt_ctl_q;
   logic [7:0] rx_delay_q, ext_delay_q, op_mode_q, gain_cfg5_q;
   logic [7:0] sqi_rb_q, rssi_rb_q, sqi_acc_q, rdata_q;
   ctac_state_t state_q, state_d;
   logic [10:0] delay_left_q;
   logic [7:0] us_cnt_q;
   logic load_delay, avg_start, avg_abort, tick, delay_done;
   logic avg_busy, avg_done, avg_done_d_q, clear_q, complete_q;
   logic [7:0] avg_val;
   logic ack_active_q, tx_start_q, ack_start_q, reject_q, sqi_we_q;
   logic cmd_wr, cmd_assess, cmd_rx, cmd_idle, cmd_tx;
   logic pkt154, filtering, autoack, frame_ok, ack_ok;
   logic [8:0] sqi_diff;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] off);
      hit = (a == ADDR_W'(off));
   endfunction : hit

   // Register writes
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         thr_q <= `CTAC_RST_BYTE;
         assess_cfg_q <= `CTAC_RST_BYTE;
         rxbuf_cfg_q <= `CTAC_RST_BYTE;
         pkt_ctl_q <= `CTAC_RST_BYTE;
         rx_delay_q <= `CTAC_RST_BYTE;
         ext_delay_q <= `CTAC_RST_BYTE;
         op_mode_q <= `CTAC_RST_BYTE;
         gain_cfg5_q <= `CTAC_RST_BYTE;
      end else if (reg_wr_in) begin
         if (hit(reg_addr_in, `CTAC_OFF_THRESHOLD)) thr_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_ASSESS_CFG)) assess_cfg_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_RXBUF_CFG)) rxbuf_cfg_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_PKT_CTL)) pkt_ctl_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_RX_DELAY)) rx_delay_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_EXT_DELAY)) ext_delay_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_OP_MODE)) op_mode_q <= reg_wdata_in;
         if (hit(reg_addr_in, `CTAC_OFF_GAIN_CFG5)) gain_cfg5_q <= reg_wdata_in;
      end
   end

   // Register reads, data in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_q <= 8'h00;
         if (hit(reg_addr_in, `CTAC_OFF_THRESHOLD)) rdata_q <= thr_q;
         if (hit(reg_addr_in, `CTAC_OFF_ASSESS_CFG)) rdata_q <= assess_cfg_q;
         if (hit(reg_addr_in, `CTAC_OFF_RXBUF_CFG)) rdata_q <= rxbuf_cfg_q;
         if (hit(reg_addr_in, `CTAC_OFF_PKT_CTL)) rdata_q <= pkt_ctl_q;
         if (hit(reg_addr_in, `CTAC_OFF_RX_DELAY)) rdata_q <= rx_delay_q;
         if (hit(reg_addr_in, `CTAC_OFF_EXT_DELAY)) rdata_q <= ext_delay_q;
         if (hit(reg_addr_in, `CTAC_OFF_OP_MODE)) rdata_q <= op_mode_q;
         if (hit(reg_addr_in, `CTAC_OFF_GAIN_CFG5)) rdata_q <= gain_cfg5_q;
         if (hit(reg_addr_in, `CTAC_OFF_SQI_RB)) rdata_q <= sqi_rb_q;
         if (hit(reg_addr_in, `CTAC_OFF_RSSI_RB)) rdata_q <= rssi_rb_q;
         if (hit(reg_addr_in, `CTAC_OFF_STATUS)) rdata_q <= {1'b0, clear_q, state_q};
      end
   end

   // Commands are writes to the command register
   assign cmd_wr = reg_wr_in && hit(reg_addr_in, `CTAC_OFF_COMMAND);
   assign cmd_assess = cmd_wr && reg_wdata_in == `CTAC_CMD_ASSESS;
   assign cmd_rx = cmd_wr && reg_wdata_in == `CTAC_CMD_RECEIVE;
   assign cmd_idle = cmd_wr && reg_wdata_in == `CTAC_CMD_GO_IDLE;
   assign cmd_tx = cmd_wr && reg_wdata_in == `CTAC_CMD_TRANSMIT;

   assign pkt154 = op_mode_q == `CTAC_MODE_PKT_154;
   // Filtering needs the add-on module; without it the enable bit is inert
   assign filtering = pkt154 && pkt_ctl_q[`CTAC_BIT_ADDON_EN] && addon_loaded_in;
   assign autoack = filtering && pkt_ctl_q[`CTAC_BIT_AUTOACK_EN];
   assign frame_ok = frame_end_in && (pkt_ctl_q[`CTAC_BIT_FCS_OFF] || fcs_ok_in)
                     && !(filtering && !dest_match_in);
   assign ack_ok = autoack && ack_request_in && frame_type_in != `CTAC_FTYPE_BEACON
                   && frame_type_in != `CTAC_FTYPE_ACK;

   // Microsecond tick, rephased on every delay load or window start
   assign tick = us_cnt_q == 8'(`CTAC_CYC_PER_US - 1);
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || load_delay || avg_start) begin
         us_cnt_q <= 8'h00;
      end else if (tick) begin
         us_cnt_q <= 8'h00;
      end else begin
         us_cnt_q <= us_cnt_q + 8'h01;
      end
   end

   // Receive delay in microseconds
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         delay_left_q <= 11'h000;
      end else if (load_delay) begin
         delay_left_q <= {3'h0, rx_delay_q}
                         + {3'h0, ext_delay_q} * 11'(`CTAC_EXT_STEP_US);
      end else if (tick && delay_left_q != 11'h000) begin
         delay_left_q <= delay_left_q - 11'h001;
      end
   end
   assign delay_done = delay_left_q == 11'h000;

   always_comb begin
      state_d = state_q;
      load_delay = 1'b0;
      avg_start = 1'b0;
      avg_abort = 1'b0;
      case (state_q)
         CTAC_IDLE: begin
         end
         CTAC_CCA_WAIT: begin
            if (delay_done) begin
               state_d = CTAC_CCA_AVG;
               avg_start = 1'b1;
            end
         end
         CTAC_CCA_AVG: begin
            if (avg_done) begin
               if (assess_cfg_q[`CTAC_BIT_CONT_CCA]) begin
                  avg_start = 1'b1;
               end else begin
                  state_d = CTAC_IDLE;
               end
            end
         end
         CTAC_RX_WAIT: begin
            if (delay_done) begin
               state_d = CTAC_RX;
               avg_start = assess_cfg_q[`CTAC_BIT_AUTO_CCA];
            end
         end
         CTAC_RX: begin
            if (frame_ok) begin
               state_d = ack_ok ? CTAC_TX : CTAC_IDLE;
            end
         end
         CTAC_TX: begin
            if (tx_done_in) begin
               if (rxbuf_cfg_q[`CTAC_BIT_TURNAROUND] && pkt154 && !ack_active_q) begin
                  state_d = CTAC_RX_WAIT;
                  load_delay = 1'b1;
               end else begin
                  state_d = CTAC_IDLE;
               end
            end
         end
         default: begin
            state_d = CTAC_IDLE;
         end
      endcase
      // Host commands override whatever the sequencer was doing
      if (cmd_idle) begin
         state_d = CTAC_IDLE;
         avg_abort = 1'b1;
         avg_start = 1'b0;
      end else if (cmd_assess || cmd_rx) begin
         state_d = cmd_assess ? CTAC_CCA_WAIT : CTAC_RX_WAIT;
         load_delay = 1'b1;
         avg_abort = 1'b1;
         avg_start = 1'b0;
      end else if (cmd_tx) begin
         state_d = CTAC_TX;
         avg_abort = 1'b1;
         avg_start = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_q <= CTAC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   ctac_rssi_avg #(
      .SAMPLE_W(8)
   ) u_avg (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .start_in(avg_start),
      .abort_in(avg_abort),
      .tick_in(tick),
      .sel_in(gain_cfg5_q[1:0]),
      .sample_in(rssi_in),
      .busy_out(avg_busy),
      .done_out(avg_done),
      .avg_out(avg_val)
   );

   // Result and readback first, done pulse one cycle later
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         clear_q <= 1'b0;
         rssi_rb_q <= 8'h00;
         avg_done_d_q <= 1'b0;
         complete_q <= 1'b0;
      end else begin
         avg_done_d_q <= avg_done && !avg_abort;
         complete_q <= avg_done_d_q;
         if (avg_done && !avg_abort) begin
            clear_q <= avg_val < thr_q;
            rssi_rb_q <= avg_val;
         end
      end
   end

   // Transmit starts and acknowledge tracking
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         tx_start_q <= 1'b0;
         ack_start_q <= 1'b0;
         ack_active_q <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         tx_start_q <= state_d == CTAC_TX && state_q != CTAC_TX;
         ack_start_q <= state_q == CTAC_RX && frame_ok && ack_ok && !cmd_wr;
         reject_q <= state_q == CTAC_RX && frame_end_in && filtering && !dest_match_in;
         if (state_q == CTAC_RX && frame_ok && ack_ok && !cmd_wr) begin
            ack_active_q <= 1'b1;
         end else if (state_d != CTAC_TX) begin
            ack_active_q <= 1'b0;
         end
      end
   end

   // Frame SQI as a running average with weight 1/8, seeded by the first sample
   assign sqi_diff = {1'b0, sqi_in} - {1'b0, sqi_acc_q};
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         sqi_acc_q <= 8'h00;
         sqi_rb_q <= 8'h00;
         sqi_we_q <= 1'b0;
      end else begin
         if (frame_start_in) begin
            sqi_acc_q <= sqi_valid_in ? sqi_in : 8'h00;
         end else if (sqi_valid_in) begin
            sqi_acc_q <= sqi_acc_q + {{2{sqi_diff[8]}}, sqi_diff[8:3]};
         end
         sqi_we_q <= frame_end_in && pkt154 && !pkt_ctl_q[`CTAC_BIT_FCS_OFF];
         if (frame_end_in) begin
            sqi_rb_q <= sqi_acc_q;
         end
      end
   end

   assign reg_rdata_out = rdata_q;
   assign radio_state_out = state_q;
   assign channel_clear_out = clear_q;
   assign cca_complete_out = complete_q;
   assign tx_start_out = tx_start_q;
   assign ack_tx_start_out = ack_start_q;
   assign frame_reject_out = reject_q;
   assign sqi_store_we_out = sqi_we_q;
   assign sqi_store_data_out = sqi_rb_q;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);

   sequence s_refresh_then_done;
      (!cca_complete_out && rssi_rb_q == $past(avg_val)) ##1 cca_complete_out;
   endsequence

   a_clear_vs_threshold: assert property (
      (avg_done && !avg_abort) |=> channel_clear_out == ($past(avg_val) < $past(thr_q)))
      else $error("channel clear flag disagrees with threshold compare");
   a_readback_before_done: assert property (
      (avg_done && !avg_abort) |=> s_refresh_then_done)
      else $error("rssi readback not refreshed one cycle before done");
   a_single_to_idle: assert property (
      (state_q == CTAC_CCA_AVG && avg_done && !cmd_wr
       && !assess_cfg_q[`CTAC_BIT_CONT_CCA]) |=> state_q == CTAC_IDLE ##1 cca_complete_out)
      else $error("single assessment did not end in idle");
   a_repeat_restart: assert property (
      (state_q == CTAC_CCA_AVG && avg_done && !cmd_wr
       && assess_cfg_q[`CTAC_BIT_CONT_CCA]) |=> state_q == CTAC_CCA_AVG && avg_busy)
      else $error("repeat assessment did not restart the window");
   a_wait_then_window: assert property (
      (state_q == CTAC_CCA_WAIT && delay_done && !cmd_wr) |=> avg_busy && !avg_done)
      else $error("averaging did not start when the delay ran out");
   a_delay_loaded: assert property (
      load_delay |=> delay_left_q == 11'($past(rx_delay_q))
                     + 11'($past(ext_delay_q)) * 11'(`CTAC_EXT_STEP_US))
      else $error("receive delay not the sum of both fields");
   a_turnaround_rx: assert property (
      (state_q == CTAC_TX && tx_done_in && !cmd_wr && pkt154 && !ack_active_q
       && rxbuf_cfg_q[`CTAC_BIT_TURNAROUND]) |=> state_q == CTAC_RX_WAIT)
      else $error("no turnaround into receive after transmit");
   a_valid_frame_idle: assert property (
      (state_q == CTAC_RX && frame_ok && !ack_ok && !cmd_wr) |=> state_q == CTAC_IDLE)
      else $error("valid frame did not return the radio to idle");
   a_ack_needs_filter: assert property (
      ack_tx_start_out |-> $past(filtering) && $past(ack_request_in))
      else $error("acknowledge started without filtering or request");
   a_ack_frame_type: assert property (
      ack_tx_start_out |-> state_q == CTAC_TX && $past(frame_type_in) != `CTAC_FTYPE_BEACON
                       && $past(frame_type_in) != `CTAC_FTYPE_ACK)
      else $error("acknowledge for beacon or acknowledge frame");
   a_reject_foreign: assert property (
      (state_q == CTAC_RX && frame_end_in && filtering && !dest_match_in) |=> frame_reject_out)
      else $error("foreign frame not rejected");
   a_sqi_store: assert property (
      (frame_end_in && pkt154 && !pkt_ctl_q[`CTAC_BIT_FCS_OFF])
      |=> sqi_store_we_out && sqi_store_data_out == $past(sqi_acc_q))
      else $error("frame quality not stored in place of checksum");
   a_auto_assess_rx: assert property (
      (state_q == CTAC_RX_WAIT && delay_done && !cmd_wr
       && assess_cfg_q[`CTAC_BIT_AUTO_CCA]) |=> state_q == CTAC_RX && avg_busy)
      else $error("receive entry did not start an assessment");
endmodule : ctac_ctrl
`default_nettype wire

// ==== include/ctac_defs.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 channel assessment / turnaround / auto-acknowledge controller.
 Assumes a 250 MHz system clock and byte-wide registers.
*/
`ifndef CTAC_DEFS_SVH
`define CTAC_DEFS_SVH

// Register offsets
`define CTAC_OFF_THRESHOLD 10'h105
`define CTAC_OFF_ASSESS_CFG 10'h106
`define CTAC_OFF_RXBUF_CFG 10'h107
`define CTAC_OFF_PKT_CTL 10'h108
`define CTAC_OFF_RX_DELAY 10'h109
`define CTAC_OFF_EXT_DELAY 10'h10B
`define CTAC_OFF_OP_MODE 10'h13E
`define CTAC_OFF_SQI_RB 10'h30D
`define CTAC_OFF_GAIN_CFG5 10'h3B9
`define CTAC_OFF_COMMAND 10'h010
`define CTAC_OFF_STATUS 10'h011
`define CTAC_OFF_RSSI_RB 10'h012

// Field positions
`define CTAC_BIT_AUTO_CCA 1
`define CTAC_BIT_CONT_CCA 2
`define CTAC_BIT_TURNAROUND 3
`define CTAC_BIT_FCS_OFF 0
`define CTAC_BIT_ADDON_EN 1
`define CTAC_BIT_AUTOACK_EN 2

// Field values and command codes
`define CTAC_MODE_PKT_154 8'h00
`define CTAC_CMD_ASSESS 8'h01
`define CTAC_CMD_RECEIVE 8'h02
`define CTAC_CMD_GO_IDLE 8'h03
`define CTAC_CMD_TRANSMIT 8'h04
`define CTAC_FTYPE_BEACON 3'h0
`define CTAC_FTYPE_ACK 3'h2

// Reset values
`define CTAC_RST_BYTE 8'h00

// Timing
`define CTAC_CLK_MHZ 250
`define CTAC_STEP_NS 1000
`define CTAC_CYC_PER_US ((`CTAC_STEP_NS * `CTAC_CLK_MHZ) / 1000)
`define CTAC_EXT_STEP_US 4
`define CTAC_AVG_BASE_US 16

`endif

// ==== include/ctac_pkg.sv ====
/*
 Types shared by the controller files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ctac_pkg;
   typedef enum logic [5:0] {
      CTAC_IDLE = 6'h01,
      CTAC_CCA_WAIT = 6'h02,
      CTAC_CCA_AVG = 6'h04,
      CTAC_RX_WAIT = 6'h08,
      CTAC_RX = 6'h10,
      CTAC_TX = 6'h20
   } ctac_state_t;
endpackage : ctac_pkg

// ==== rtl/ctac_rssi_avg.sv ====
/*
 RSSI averaging window: sums one sample per microsecond tick over
 16, 32, 64 or 128 ticks and returns the mean with a one-cycle done pulse.
 Assumes tick and sample come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ctac_defs.svh"
module ctac_rssi_avg #(
   parameter int unsigned SAMPLE_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic tick_in,
   input wire logic [1:0] sel_in,
   input wire logic [SAMPLE_W-1:0] sample_in,
   output logic busy_out,
   output logic done_out,
   output logic [SAMPLE_W-1:0] avg_out
);
   logic [SAMPLE_W+6:0] sum_q;
   logic [6:0] cnt_q;
   logic [1:0] sel_q;
   logic [SAMPLE_W+6:0] sum_next;
   logic [6:0] last_cnt;

   assign sum_next = sum_q + {7'h00, sample_in};
   // Window of 16 << sel microseconds
   assign last_cnt = 7'((`CTAC_AVG_BASE_US << sel_q) - 1);

   always_ff @(posedge clk_sys_in) begin
      if (reset_in || abort_in) begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
         sum_q <= '0;
         cnt_q <= 7'h00;
         sel_q <= 2'h0;
      end else if (start_in) begin
         busy_out <= 1'b1;
         done_out <= 1'b0;
         sum_q <= '0;
         cnt_q <= 7'h00;
         sel_q <= sel_in;
      end else begin
         done_out <= 1'b0;
         if (busy_out && tick_in) begin
            sum_q <= sum_next;
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == last_cnt) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end

   // Mean by shift; the window lengths are powers of two for this reason
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         avg_out <= '0;
      end else if (busy_out && tick_in && cnt_q == last_cnt) begin
         avg_out <= SAMPLE_W'(sum_next >> (3'h4 + {1'b0, sel_q}));
      end
   end
endmodule : ctac_rssi_avg
`default_nettype wire

// ==== verif/ctac_host_model.sv ====
/*
 Host microcontroller model: master of the plain register port.
 Assumes the controller samples its strobes on rising clk_sys_in edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ctac_defs.svh"
module ctac_host_model (
   input wire logic clk_sys_in,
   input wire logic [7:0] rdata_in,
   output logic [9:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   output logic addon_loaded_out
);
   initial begin
      addr_out = 10'h000;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      addon_loaded_out = 1'b0;
   end
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_sys_in);
      wr_out <= 1'b0;
   endtask : wr
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_sys_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask : rd
   // Firmware must be present before filtering or auto-acknowledge is asked for
   task automatic load_addon;
      @(posedge clk_sys_in);
      addon_loaded_out <= 1'b1;
   endtask : load_addon
   task automatic mode154;
      wr(`CTAC_OFF_OP_MODE, `CTAC_MODE_PKT_154);
      wr(`CTAC_OFF_GAIN_CFG5, 8'h02);
   endtask : mode154
endmodule : ctac_host_model
`default_nettype wire

// ==== verif/tb.sv ====
/*
 Self-checking bench for ctac_ctrl: registers, assessment timing, frames.
 Assumes ctac_host_model masters the register port.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ctac_pkg::*;
   typedef struct {logic [9:0] a; logic [7:0] r, w, e;} ctac_row_t;
   typedef struct {logic [7:0] s, v, t, c;} ctac_cca_t;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic [7:0] rssi = 8'h00, sqi = 8'h00, rdata, d, sqd;
   logic sqv = 1'b0, fs = 1'b0, fe = 1'b0, fok = 1'b0, dm = 1'b0, ak = 1'b0, txd = 1'b0;
   logic [2:0] ft = 3'h0;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic wr, rd, addon, clr, cc, txs, ack, rej, we;
   logic [5:0] st;
   logic [3:0] fl;
   int miscompares = 0, n_compared = 0, cyc = 0, n;
   // Value read before the write, value written, value read back
   ctac_row_t rows[14] = '{'{10'h105, 8'h00, 8'hA5, 8'hA5}, '{10'h106, 8'h00, 8'h5A, 8'h5A},
      '{10'h107, 8'h00, 8'h3C, 8'h3C}, '{10'h108, 8'h00, 8'hC3, 8'hC3},
      '{10'h109, 8'h00, 8'h5A, 8'h5A}, '{10'h10B, 8'h00, 8'hA5, 8'hA5},
      '{10'h109, 8'h5A, 8'h00, 8'h00}, '{10'h10B, 8'hA5, 8'h00, 8'h00},
      '{10'h13E, 8'h00, 8'h04, 8'h04}, '{10'h3B9, 8'h00, 8'h03, 8'h03},
      '{10'h30D, 8'h00, 8'hFF, 8'h00}, '{10'h012, 8'h00, 8'hFF, 8'h00},
      '{10'h011, 8'h01, 8'hFF, 8'h01}, '{10'h200, 8'h00, 8'hFF, 8'h00}};
   // Averaging select, RSSI, threshold, expected clear flag
   ctac_cca_t ccas[4] = '{'{8'h00, 8'h40, 8'h80, 8'h01}, '{8'h01, 8'h80, 8'h80, 8'h00},
      '{8'h02, 8'h7F, 8'h80, 8'h01}, '{8'h03, 8'hFF, 8'h00, 8'h00}};
   ctac_host_model host (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .addon_loaded_out(addon));
   ctac_ctrl DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .rssi_in(rssi),
      .sqi_valid_in(sqv), .sqi_in(sqi), .addon_loaded_in(addon), .frame_start_in(fs),
      .frame_end_in(fe), .fcs_ok_in(fok), .dest_match_in(dm), .frame_type_in(ft),
      .ack_request_in(ak), .tx_done_in(txd), .reg_rdata_out(rdata), .radio_state_out(st),
      .channel_clear_out(clr), .cca_complete_out(cc), .tx_start_out(txs),
      .ack_tx_start_out(ack), .frame_reject_out(rej), .sqi_store_we_out(we),
      .sqi_store_data_out(sqd));
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // The longest run is near 74000 cycles
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic rdc(input logic [9:0] a, input logic [7:0] e);
      host.rd(a, d);
      chk(d, e);
   endtask : rdc
   task automatic st_is(input logic [7:0] e);
      repeat (3) @(posedge clk_sys_in);
      #1;
      chk({2'b00, st}, e);
   endtask : st_is
   // Counts edges up to the next completion pulse, bounded
   task automatic wcc;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end while (cc !== 1'b1 && n < 40000);
   endtask : wcc
   task automatic win(input int lo, input int hi);
      chk({7'h00, (n >= lo) && (n <= hi)}, 8'h01);
   endtask : win
   task automatic frm(input logic [2:0] t, input logic m, input logic k, input logic o);
      @(posedge clk_sys_in);
      fs <= 1'b1;
      sqv <= 1'b1;
      sqi <= 8'h33;
      @(posedge clk_sys_in);
      fs <= 1'b0;
      sqv <= 1'b0;
      @(posedge clk_sys_in);
      fe <= 1'b1;
      ft <= t;
      dm <= m;
      ak <= k;
      fok <= o;
      @(posedge clk_sys_in);
      fe <= 1'b0;
      fl = 4'h0;
      repeat (4) begin
         #1;
         fl = fl | {rej, ack, txs, we};
         @(posedge clk_sys_in);
      end
   endtask : frm
   task automatic txp;
      @(posedge clk_sys_in);
      txd <= 1'b1;
      @(posedge clk_sys_in);
      txd <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
   endtask : txp
   initial begin
      repeat (20) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      foreach (rows[i]) begin
         rdc(rows[i].a, rows[i].r);
         host.wr(rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].e);
      end
      foreach (ccas[i]) begin
         host.wr(10'h105, ccas[i].t);
         host.wr(10'h3B9, ccas[i].s);
         rssi <= ccas[i].v;
         host.wr(10'h010, 8'h01);
         wcc();
         win(250 * (16 << ccas[i].s) - 250, 250 * (16 << ccas[i].s) + 260);
         chk({7'h00, clr}, ccas[i].c);
         chk({2'b00, st}, 8'h01);
         rdc(10'h012, ccas[i].v);
      end
      host.wr(10'h3B9, 8'h00);
      host.wr(10'h105, 8'h80);
      host.wr(10'h109, 8'h02);
      host.wr(10'h10B, 8'h01);
      host.wr(10'h106, 8'h04);
      rssi <= 8'h10;
      host.wr(10'h010, 8'h01);
      repeat (1400) @(posedge clk_sys_in);
      #1;
      chk({2'b00, st}, 8'h02);
      wcc();
      n = n + 1400;
      win(5250, 5760);
      chk({2'b00, st}, 8'h04);
      @(posedge clk_sys_in);
      rssi <= 8'h90;
      repeat (999) @(posedge clk_sys_in);
      rdc(10'h012, 8'h10);
      wcc();
      win(2740, 3260);
      chk({7'h00, clr}, 8'h00);
      rdc(10'h012, 8'h90);
      host.wr(10'h010, 8'h03);
      st_is(8'h01);
      host.wr(10'h10B, 8'h00);
      host.wr(10'h109, 8'h00);
      host.wr(10'h106, 8'h02);
      rssi <= 8'h20;
      host.wr(10'h010, 8'h02);
      st_is(8'h10);
      wcc();
      win(3500, 4300);
      chk({7'h00, clr}, 8'h01);
      host.mode154();
      host.load_addon();
      host.wr(10'h106, 8'h00);
      host.wr(10'h108, 8'h06);
      host.wr(10'h107, 8'h08);
      frm(3'h1, 1'b0, 1'b1, 1'b1);
      chk({4'h0, fl}, 8'h09);
      chk(sqd, 8'h33);
      rdc(10'h30D, 8'h33);
      frm(3'h0, 1'b1, 1'b1, 1'b1);
      chk({4'h0, fl}, 8'h01);
      host.wr(10'h010, 8'h02);
      frm(3'h2, 1'b1, 1'b1, 1'b1);
      chk({4'h0, fl}, 8'h01);
      host.wr(10'h010, 8'h02);
      frm(3'h1, 1'b1, 1'b0, 1'b1);
      chk({4'h0, fl}, 8'h01);
      host.wr(10'h010, 8'h02);
      frm(3'h1, 1'b1, 1'b1, 1'b1);
      chk({4'h0, fl}, 8'h07);
      txp();
      chk({2'b00, st}, 8'h01);
      host.wr(10'h010, 8'h04);
      st_is(8'h20);
      txp();
      chk({2'b00, st}, 8'h10);
      frm(3'h1, 1'b1, 1'b0, 1'b1);
      chk({2'b00, st}, 8'h01);
      host.wr(10'h108, 8'h05);
      host.wr(10'h010, 8'h02);
      frm(3'h1, 1'b0, 1'b1, 1'b0);
      chk({4'h0, fl}, 8'h00);
      chk({2'b00, st}, 8'h01);
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      #1;
      chk({2'b00, st}, 8'h01);
      rdc(10'h105, 8'h00);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
